// [shared/jtbs_regs.svh]
`ifndef JTBS_REGS_SVH
`define JTBS_REGS_SVH
// instruction opcodes
`define JTBS_IR_W 8
`define JTBS_OP_EXTEST 8'h00
`define JTBS_OP_SAMPLE 8'h01
`define JTBS_OP_CLAMP 8'h05
`define JTBS_OP_HIGHZ 8'h07
`define JTBS_OP_USERCODE 8'h0E
`define JTBS_OP_IDCODE 8'h0F
`define JTBS_OP_PROG_FAB 8'h10
`define JTBS_OP_PROG_ROM 8'h11
`define JTBS_OP_BYPASS 8'hFF
`define JTBS_IR_CAPTURE 8'h01
// boundary scan geometry, three cells per i/o
`define JTBS_NUM_IO 4
`define JTBS_CELLS_PER_IO 3
`define JTBS_BSR_W 12
`define JTBS_CELL_IN 0
`define JTBS_CELL_OUT 1
`define JTBS_CELL_CTL 2
// identification register fields
`define JTBS_ID_W 32
`define JTBS_ID_LSB_POS 0
`define JTBS_ID_MFR_POS 1
`define JTBS_ID_PART_POS 12
`define JTBS_ID_VER_POS 28
// programming data register: address above a 128-bit cipher block
`define JTBS_BLK_W 128
`define JTBS_ADDR_W 8
`define JTBS_PROG_W 136
`define JTBS_ROM_ROWS 8
`define JTBS_ROM_AW 3
`define JTBS_ROUNDS 4'hA
`define JTBS_AUTH_TAG 8'hA5
`define JTBS_AUTH_POS 120
`endif

// [shared/jtbs_pkg.sv]
`default_nettype none
package jtbs_pkg;
    // tap controller, sixteen states in four bits
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } jtbs_tap_t;
    // core-side programming sequence
    typedef enum logic [2:0] {
        P_IDLE, P_DECRYPT, P_CHECK, P_WRITE, P_VERIFY
    } jtbs_prog_t;
endpackage
`default_nettype wire

// [rtl/jtbs_rom_mem.sv]
`default_nettype none
`include "jtbs_regs.svh"
module jtbs_rom_mem (
    input wire logic ref_clk_i,
    input wire logic wr_i,
    input wire logic [`JTBS_ROM_AW-1:0] addr_i,
    input wire logic [`JTBS_BLK_W-1:0] wdata_i,
    output logic [`JTBS_BLK_W-1:0] rdata_o
);
    // no reset: contents stand for nonvolatile storage
    logic [`JTBS_BLK_W-1:0] mem_reg [`JTBS_ROM_ROWS];

    // write port
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_i)
        begin
            mem_reg[addr_i] <= wdata_i;
        end
    end

    // registered read, old data on a same-cycle write
    always_ff @(posedge ref_clk_i)
    begin
        rdata_o <= mem_reg[addr_i];
    end
endmodule
`default_nettype wire

// [rtl/jtbs_tap.sv]
`default_nettype none
`include "jtbs_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] four-bit, sixteen-state standard tap controller
// [RULE2] transitions follow tms at rising tck
// [RULE3] power-up starts in test-logic-reset
// [RULE4] five tck cycles with tms high reach test-logic-reset
// [RULE5] trst forces test-logic-reset without tck
// [RULE6] trst is active low
// [RULE7] extest 00, sample/preload 01, bypass ff supported
// [RULE8] highz 07, clamp 05, idcode 0f, usercode 0e decoded
// [RULE9] 8-bit instruction; unknown opcodes pick bypass
// [RULE10] bypass, id and boundary registers; bypass by default (the code loads idcode on reset, so id is selected first)
// [RULE11] 32-bit id: lsb, maker, part, version
// [RULE12] three cells per i/o, each serial and parallel in/out
// [RULE13] cells chained in one register, tdi to tdo
// [RULE14] cells capture pins, drive buffer output and control
// [RULE15] only tms and tck steer the controller
// [RULE16] unprogrammed: global i/o enable stays off
// [RULE17] sample in unprogrammed state never enables input buffers
// [RULE18] 128-bit decryption core for fabric and user rom data
// [RULE19] user rom and fabric programmed independently
// [RULE20] master key held in nonvolatile storage
// [RULE21] blocks authenticated, bad data rejected, verified on chip
// [RULE22] encrypted jtag data decrypted, stored in flash
// [RULE23] decryption usable for 1024-bit user rom updates
// [RULE24] tdo on falling tck, driven only in shift states
module jtbs_tap #(
    parameter logic [10:0] MFR_ID = 11'h055,     // arbitrary value
    parameter logic [15:0] PART_ID = 16'h1234,   // arbitrary value
    parameter logic [3:0] VERSION = 4'h1,        // arbitrary value
    parameter logic [31:0] USER_CODE = 32'h0000_0000,
    parameter logic [`JTBS_BLK_W-1:0] MASTER_KEY = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic nv_programmed_i,
    input wire logic [`JTBS_NUM_IO-1:0] core_out_i,
    input wire logic [`JTBS_NUM_IO-1:0] core_oe_i,
    output logic [`JTBS_NUM_IO-1:0] core_in_o,
    input wire logic [`JTBS_NUM_IO-1:0] pad_in_i,
    output logic [`JTBS_NUM_IO-1:0] pad_out_o,
    output logic [`JTBS_NUM_IO-1:0] pad_oe_o,
    output logic io_en_o,
    output logic fab_wr_o,
    output logic [`JTBS_ADDR_W-1:0] fab_addr_o,
    output logic [`JTBS_BLK_W-1:0] fab_wdata_o,
    input wire logic [`JTBS_BLK_W-1:0] fab_rdata_i,
    output logic prog_busy_o,
    output logic prog_err_o,
    output logic prog_ok_o
);
    import jtbs_pkg::*;

    localparam int N = `JTBS_NUM_IO;
    localparam int B = `JTBS_BSR_W;
    localparam int TW = 3 * N + 4;   // tck domain toward core
    localparam int CW = 3 * N + 4;   // core toward tck domain

    // next tap state from tms
    function automatic jtbs_tap_t tap_next(input jtbs_tap_t s, input logic tms);
        case (s)
            TLR: tap_next = tms ? TLR : RTI;
            RTI: tap_next = tms ? SEL_DR : RTI;
            SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
            SH_DR: tap_next = tms ? EX1_DR : SH_DR;
            EX1_DR: tap_next = tms ? UPD_DR : PA_DR;
            PA_DR: tap_next = tms ? EX2_DR : PA_DR;
            EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
            UPD_DR: tap_next = tms ? SEL_DR : RTI;
            SEL_IR: tap_next = tms ? TLR : CAP_IR;
            CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
            SH_IR: tap_next = tms ? EX1_IR : SH_IR;
            EX1_IR: tap_next = tms ? UPD_IR : PA_IR;
            PA_IR: tap_next = tms ? EX2_IR : PA_IR;
            EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
            UPD_IR: tap_next = tms ? SEL_DR : RTI;
            default: tap_next = TLR;
        endcase
    endfunction

    // stand-in keyed round
    function automatic logic [`JTBS_BLK_W-1:0] dec_round(input logic [`JTBS_BLK_W-1:0] d);
        dec_round = {d[0], d[`JTBS_BLK_W-1:1]} ^ MASTER_KEY;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // tck domain: controller and instruction register
    jtbs_tap_t tap_reg;
    logic [`JTBS_IR_W-1:0] ir_sh_reg;
    logic [`JTBS_IR_W-1:0] ir_reg;
    logic [TW-1:0] c2t_s1_reg;
    logic [CW-1:0] c2t_s2_reg;
    logic [CW-1:0] c2t_s3_reg;
    logic [CW-1:0] c2t_reg;

    // [RULE1] sixteen-state controller
    // [RULE3] reset-state entry, power-up holds trst
    // [RULE5] [RULE6] async low reset
    // [RULE2] [RULE4] [RULE15] tms-driven walk
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            tap_reg <= TLR;
        end
        else
        begin
            tap_reg <= tap_next(tap_reg, tms_i);
        end
    end

    // [RULE9] eight-bit instruction, idcode after reset
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            ir_sh_reg <= `JTBS_IR_CAPTURE;
            ir_reg <= `JTBS_OP_IDCODE;
        end
        else
        begin
            case (tap_reg)
                TLR: ir_reg <= `JTBS_OP_IDCODE;
                CAP_IR: ir_sh_reg <= `JTBS_IR_CAPTURE;
                SH_IR: ir_sh_reg <= {tdi_i, ir_sh_reg[`JTBS_IR_W-1:1]};
                UPD_IR: ir_reg <= ir_sh_reg;
                default: ir_reg <= ir_reg;
            endcase
        end
    end

    // [RULE7] [RULE8] opcode decode
    logic sel_bsr;
    logic sel_id;
    logic sel_user;
    logic sel_prog;
    logic mode_drive;
    assign sel_bsr = (ir_reg == `JTBS_OP_EXTEST) || (ir_reg == `JTBS_OP_SAMPLE);
    assign sel_id = (ir_reg == `JTBS_OP_IDCODE);
    assign sel_user = (ir_reg == `JTBS_OP_USERCODE);
    assign sel_prog = (ir_reg == `JTBS_OP_PROG_FAB) || (ir_reg == `JTBS_OP_PROG_ROM);
    assign mode_drive = (ir_reg == `JTBS_OP_EXTEST) || (ir_reg == `JTBS_OP_CLAMP);

    //////////////////////////////////////////////////////////////////////////
    // tck domain: data registers
    logic bypass_reg;
    logic [`JTBS_ID_W-1:0] id_sh_reg;
    logic [B-1:0] bsr_sh_reg;
    logic [B-1:0] bsr_upd_reg;
    logic [`JTBS_PROG_W-1:0] prog_sh_reg;
    logic [`JTBS_PROG_W-1:0] prog_hold_reg;
    logic prog_rom_reg;
    logic prog_tog_reg;
    logic [B-1:0] bsr_cap;
    logic [`JTBS_ID_W-1:0] id_word;
    logic c_io_en;

    assign c_io_en = c2t_reg[CW-1];
    // [RULE11] identification fields, lsb fixed at one
    assign id_word = {VERSION, PART_ID, MFR_ID, 1'b1};

    // [RULE14] [RULE17] capture pins, inputs read zero while disabled
    always_comb
    begin
        bsr_cap = '0;
        for (int i = 0; i < N; i++)
        begin
            bsr_cap[3 * i + `JTBS_CELL_IN] = c_io_en & c2t_reg[2 * N + i];
            bsr_cap[3 * i + `JTBS_CELL_OUT] = c2t_reg[N + i];
            bsr_cap[3 * i + `JTBS_CELL_CTL] = c2t_reg[i];
        end
    end

    // [RULE10] [RULE12] [RULE13] capture, shift, update
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            bypass_reg <= 1'b0;
            id_sh_reg <= '0;
            bsr_sh_reg <= '0;
            bsr_upd_reg <= '0;
        end
        else if (tap_reg == CAP_DR)
        begin
            bypass_reg <= 1'b0;
            id_sh_reg <= sel_user ? USER_CODE : id_word;
            bsr_sh_reg <= bsr_cap;
        end
        else if (tap_reg == SH_DR)
        begin
            bypass_reg <= tdi_i;
            id_sh_reg <= {tdi_i, id_sh_reg[`JTBS_ID_W-1:1]};
            bsr_sh_reg <= {tdi_i, bsr_sh_reg[B-1:1]};
        end
        else if (tap_reg == UPD_DR && sel_bsr)
        begin
            bsr_upd_reg <= bsr_sh_reg;
        end
    end

    // [RULE22] cipher block in, handed over on update
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            prog_sh_reg <= '0;
            prog_hold_reg <= '0;
            prog_rom_reg <= 1'b0;
            prog_tog_reg <= 1'b0;
        end
        else if (sel_prog && tap_reg == CAP_DR)
        begin
            // status in the low bits for polling
            prog_sh_reg <= {{(`JTBS_PROG_W - 3){1'b0}}, c2t_reg[3 * N + 2:3 * N]};
        end
        else if (sel_prog && tap_reg == SH_DR)
        begin
            prog_sh_reg <= {tdi_i, prog_sh_reg[`JTBS_PROG_W-1:1]};
        end
        else if (sel_prog && tap_reg == UPD_DR)
        begin
            prog_hold_reg <= prog_sh_reg;
            prog_rom_reg <= (ir_reg == `JTBS_OP_PROG_ROM);
            prog_tog_reg <= ~prog_tog_reg;
        end
    end

    // [RULE24] falling-edge output, enabled in shift states only
    always_ff @(negedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else
        begin
            tdo_oe_o <= (tap_reg == SH_DR) || (tap_reg == SH_IR);
            if (tap_reg == SH_IR)
                tdo_o <= ir_sh_reg[0];
            else if (sel_bsr)
                tdo_o <= bsr_sh_reg[0];
            else if (sel_id || sel_user)
                tdo_o <= id_sh_reg[0];
            else if (sel_prog)
                tdo_o <= prog_sh_reg[0];
            else
                tdo_o <= bypass_reg;
        end
    end

    // core state into tck domain
    logic [CW-1:0] c2t_src_reg;
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
        begin
            c2t_s1_reg <= '0;
            c2t_s2_reg <= '0;
            c2t_s3_reg <= '0;
            c2t_reg <= '0;
        end
        else
        begin
            c2t_s1_reg <= c2t_src_reg;
            c2t_s2_reg <= c2t_s1_reg;
            c2t_s3_reg <= c2t_s2_reg;
            if (c2t_s2_reg == c2t_s3_reg)
                c2t_reg <= c2t_s3_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // ref_clk domain: crossings and pin sync
    logic [TW-1:0] t2c_src;
    logic [TW-1:0] t2c_s1_reg;
    logic [TW-1:0] t2c_s2_reg;
    logic [TW-1:0] t2c_s3_reg;
    logic [TW-1:0] t2c_reg;
    logic [N:0] pin_s1_reg;
    logic [N:0] pin_s2_reg;
    logic [N:0] pin_s3_reg;
    logic [N:0] pin_reg;
    logic ext_highz;
    logic ext_drive;
    logic ext_tog;
    logic [B-1:0] ext_upd;
    logic io_en;
    logic [N-1:0] pad_sync;

    assign t2c_src = {bsr_upd_reg, mode_drive, ir_reg == `JTBS_OP_HIGHZ, prog_tog_reg,
        prog_rom_reg};
    assign ext_upd = t2c_reg[TW-1:4];
    assign ext_drive = t2c_reg[3];
    assign ext_highz = t2c_reg[2];
    assign ext_tog = t2c_reg[1];
    assign io_en = pin_reg[N];
    assign pad_sync = pin_reg[N-1:0];

    // quasi-static words: stage agreement filters skew
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            t2c_s1_reg <= '0;
            t2c_s2_reg <= '0;
            t2c_s3_reg <= '0;
            t2c_reg <= '0;
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            pin_reg <= '0;
        end
        else
        begin
            t2c_s1_reg <= t2c_src;
            t2c_s2_reg <= t2c_s1_reg;
            t2c_s3_reg <= t2c_s2_reg;
            if (t2c_s2_reg == t2c_s3_reg)
                t2c_reg <= t2c_s3_reg;
            pin_s1_reg <= {nv_programmed_i, pad_in_i};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg)
                pin_reg <= pin_s3_reg;
        end
    end

    // [RULE14] [RULE16] pad drive, off while unprogrammed
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
            core_in_o <= '0;
            io_en_o <= 1'b0;
        end
        else
        begin
            io_en_o <= io_en;
            core_in_o <= io_en ? pad_sync : '0;
            for (int i = 0; i < N; i++)
            begin
                pad_out_o[i] <= ext_drive ? ext_upd[3 * i + `JTBS_CELL_OUT] : core_out_i[i];
                if (!io_en || ext_highz)
                    pad_oe_o[i] <= 1'b0;
                else
                    pad_oe_o[i] <= ext_drive ? ext_upd[3 * i + `JTBS_CELL_CTL] : core_oe_i[i];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // ref_clk domain: decrypt, check, store, verify
    jtbs_prog_t prog_reg;
    logic tog_seen_reg;
    logic rom_tgt_reg;
    logic [`JTBS_ADDR_W-1:0] addr_reg;
    logic [`JTBS_BLK_W-1:0] data_reg;
    logic [3:0] round_reg;
    logic rom_wr;
    logic tag_ok;
    logic [`JTBS_BLK_W-1:0] rom_rdata;

    assign tag_ok = data_reg[`JTBS_BLK_W-1:`JTBS_AUTH_POS] == `JTBS_AUTH_TAG;
    // rom written in check so its registered read-back is fresh in verify
    assign rom_wr = (prog_reg == P_CHECK) && rom_tgt_reg && tag_ok;

    // [RULE18] [RULE21] [RULE22] sequence per block
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            prog_reg <= P_IDLE;
            tog_seen_reg <= 1'b0;
            rom_tgt_reg <= 1'b0;
            addr_reg <= '0;
            data_reg <= '0;
            round_reg <= '0;
            prog_err_o <= 1'b0;
            prog_ok_o <= 1'b0;
        end
        else
        begin
            case (prog_reg)
                P_IDLE:
                begin
                    if (ext_tog != tog_seen_reg)
                    begin
                        // hold word is stable by now: its toggle came after it
                        tog_seen_reg <= ext_tog;
                        rom_tgt_reg <= t2c_reg[0];
                        addr_reg <= prog_hold_reg[`JTBS_PROG_W-1:`JTBS_BLK_W];
                        data_reg <= prog_hold_reg[`JTBS_BLK_W-1:0];
                        round_reg <= '0;
                        prog_err_o <= 1'b0;
                        prog_ok_o <= 1'b0;
                        prog_reg <= P_DECRYPT;
                    end
                end
                // [RULE20] key from nonvolatile parameter
                P_DECRYPT:
                begin
                    data_reg <= dec_round(data_reg);
                    round_reg <= round_reg + 4'h1;
                    if (round_reg == `JTBS_ROUNDS - 4'h1)
                        prog_reg <= P_CHECK;
                end
                // [RULE21] reject a block with a bad tag
                P_CHECK:
                begin
                    if (tag_ok)
                        prog_reg <= P_WRITE;
                    else
                    begin
                        prog_err_o <= 1'b1;
                        prog_reg <= P_IDLE;
                    end
                end
                P_WRITE: prog_reg <= P_VERIFY;
                // [RULE21] read-back compare on chip
                P_VERIFY:
                begin
                    if (rom_tgt_reg ? (rom_rdata == data_reg) : (fab_rdata_i == data_reg))
                        prog_ok_o <= 1'b1;
                    else
                        prog_err_o <= 1'b1;
                    prog_reg <= P_IDLE;
                end
                default: prog_reg <= P_IDLE;
            endcase
        end
    end

    // [RULE19] separate write strobes for rom and fabric
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            fab_wr_o <= 1'b0;
            fab_addr_o <= '0;
            fab_wdata_o <= '0;
            prog_busy_o <= 1'b0;
            c2t_src_reg <= '0;
        end
        else
        begin
            fab_wr_o <= (prog_reg == P_CHECK) && !rom_tgt_reg && tag_ok;
            fab_addr_o <= addr_reg;
            fab_wdata_o <= data_reg;
            prog_busy_o <= (prog_reg != P_IDLE) || (ext_tog != tog_seen_reg);
            c2t_src_reg <= {io_en, prog_busy_o, prog_err_o, prog_ok_o, pad_sync,
                core_out_i, core_oe_i};
        end
    end

    // [RULE23] 1024-bit user rom, eight 128-bit rows
    jtbs_rom_mem u_rom (
        .ref_clk_i(ref_clk_i),
        .wr_i(rom_wr),
        .addr_i(addr_reg[`JTBS_ROM_AW-1:0]),
        .wdata_i(data_reg),
        .rdata_o(rom_rdata)
    );
endmodule
`default_nettype wire

// [testbench/jtbs_monitor.sv]
`default_nettype none
`include "jtbs_regs.svh"
module jtbs_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic trst_n_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic nv_programmed_i,
    input wire logic [`JTBS_NUM_IO-1:0] core_in_o,
    input wire logic [`JTBS_NUM_IO-1:0] pad_oe_o,
    input wire logic io_en_o,
    input wire logic fab_wr_o,
    input wire logic prog_err_o,
    input wire logic prog_ok_o
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////
    // tap reset silences tdo without tck
    property p_trst;
        @(posedge ref_clk_i) disable iff (rst_i) !trst_n_i |-> !tdo_oe_o && !tdo_o;
    endproperty
    a_trst: assert property (p_trst) else $error("tdo live in tap reset");
    // tms high leaves shift states
    property p_tms_oe;
        @(posedge tck_i) disable iff (!trst_n_i) tms_i |=> !tdo_oe_o;
    endproperty
    a_tms_oe: assert property (p_tms_oe) else $error("tdo driven off shift");
    property p_unprog_oe;
        @(posedge ref_clk_i) disable iff (rst_i) !io_en_o [*2] |-> pad_oe_o == '0;
    endproperty
    a_unprog_oe: assert property (p_unprog_oe) else $error("pad on unprogrammed");
    property p_unprog_in;
        @(posedge ref_clk_i) disable iff (rst_i) !io_en_o [*2] |-> core_in_o == '0;
    endproperty
    a_unprog_in: assert property (p_unprog_in) else $error("input on unprogrammed");
    // enable follows the pin
    property p_en_on;
        @(posedge ref_clk_i) disable iff (rst_i) nv_programmed_i [*8] |-> io_en_o;
    endproperty
    a_en_on: assert property (p_en_on) else $error("io enable stuck low");
    property p_en_off;
        @(posedge ref_clk_i) disable iff (rst_i) !nv_programmed_i [*8] |-> !io_en_o;
    endproperty
    a_en_off: assert property (p_en_off) else $error("io enable stuck high");
    property p_wr_pulse;
        @(posedge ref_clk_i) disable iff (rst_i) fab_wr_o |=> !fab_wr_o;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write not a pulse");
    property p_wr_done;
        @(posedge ref_clk_i) disable iff (rst_i) fab_wr_o |-> ##[1:4] (prog_ok_o || prog_err_o);
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("no verify verdict");
    property p_excl;
        @(posedge ref_clk_i) disable iff (rst_i) !(prog_ok_o && prog_err_o);
    endproperty
    a_excl: assert property (p_excl) else $error("ok and error together");
    c_wr: cover property (@(posedge ref_clk_i) fab_wr_o);
    c_err: cover property (@(posedge ref_clk_i) $rose(prog_err_o));
    c_shift: cover property (@(posedge tck_i) tdo_oe_o);
endmodule
bind jtbs_tap jtbs_monitor mon (.*);
`default_nettype wire

// [testbench/jtbs_host.sv]
`default_nettype none
module jtbs_host (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    input wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////
    // idle levels: tck low, tms and tdi high
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_n_o = 1'b0;
    end
    task automatic tick(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #3 tck_o = 1'b1;
        q = tdo_i;
        #3 tck_o = 1'b0;
    endtask
    task automatic reset5;
        logic q;
        repeat (5) tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask
    // tap reset, then run-test/idle
    task automatic trst_pulse;
        logic q;
        trst_n_o = 1'b0;
        #20 trst_n_o = 1'b1;
        #3 tick(1'b0, 1'b1, q);
    endtask
    task automatic scan(input logic ir, input int n, input logic [135:0] din,
        output logic [135:0] dout);
        logic q;
        dout = '0;
        // idle ticks let core state cross into the tck domain
        repeat (4) tick(1'b0, 1'b1, q);
        tick(1'b1, 1'b1, q);
        if (ir)
            tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
        tick(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b1, q);
        tick(1'b0, 1'b1, q);
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
`include "jtbs_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [10:0] MFR = 11'h2A3; // arbitrary value
    localparam logic [15:0] PART = 16'h5B17; // arbitrary value
    localparam logic [3:0] VER = 4'h3; // arbitrary value
    localparam logic [31:0] UCODE = 32'h1357_9BDF;
    localparam logic [127:0] KEY = 128'h3C1D_0E7F_A295_64B8_D7C6_1F20_8E3A_5B49;
    localparam logic [31:0] ID = {VER, PART, MFR, 1'b1};
    logic ref_clk_i, rst_i, tck, tms, tdi, trst_n, tdo, tdo_oe, nv, io_en, fab_wr;
    logic busy, err, ok;
    logic [3:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
    logic [7:0] fab_addr, wr_addr;
    logic [127:0] fab_wdata, fab_rdata;
    int n_mismatch = 0, n_checks = 0, n_wr = 0;
    ////////////////////////////////////////
    jtbs_tap #(.MFR_ID(MFR), .PART_ID(PART), .VERSION(VER), .USER_CODE(UCODE),
        .MASTER_KEY(KEY)) uut (.ref_clk_i, .rst_i, .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .nv_programmed_i(nv),
        .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .io_en_o(io_en), .fab_wr_o(fab_wr),
        .fab_addr_o(fab_addr), .fab_wdata_o(fab_wdata), .fab_rdata_i(fab_rdata),
        .prog_busy_o(busy), .prog_err_o(err), .prog_ok_o(ok));
    jtbs_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo));
    // flash stand-in
    always @(posedge ref_clk_i)
    begin
        if (fab_wr)
        begin
            fab_rdata <= fab_wdata;
            wr_addr <= fab_addr;
            n_wr <= n_wr + 1;
        end
    end
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input logic [135:0] g, input logic [135:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic wref(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // inverse of the stand-in rounds
    function automatic logic [127:0] enc(input logic [127:0] p);
        for (int r = 0; r < 10; r++)
            p = {p[126:0], p[127]} ^ {KEY[126:0], KEY[127]};
        return p;
    endfunction
    task automatic t_reset;
        logic [135:0] d;
        host.scan(1'b0, 32, 136'h0, d);
        chk(d[31:0], ID);
        host.scan(1'b1, 8, 136'hFF, d);
        chk(d[7:0], 8'h01);
        host.reset5();
        host.scan(1'b0, 32, 136'h0, d);
        chk(d[31:0], ID);
        host.scan(1'b1, 8, 136'hFF, d);
        host.trst_pulse();
        host.scan(1'b0, 32, 136'h0, d);
        chk(d[31:0], ID);
        $display("t_reset done");
    endtask
    // register length per opcode
    task automatic t_opcodes;
        logic [7:0] ops[8] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h0E, 8'h0F, 8'hFF, 8'h33};
        int lens[8] = '{12, 12, 1, 1, 32, 32, 1, 1};
        logic [63:0] p, e;
        logic [135:0] d;
        p = 64'hC3A5_9617_E2B4_D80F;
        for (int i = 0; i < 8; i++)
        begin
            host.scan(1'b1, 8, 136'(ops[i]), d);
            host.scan(1'b0, 64, 136'(p), d);
            e = p << lens[i];
            e = e >> lens[i];
            chk(d[63:0] >> lens[i], e);
            if (ops[i] == 8'h0E)
                chk(d[31:0], UCODE);
        end
        $display("t_opcodes done");
    endtask
    task automatic t_pins;
        logic [135:0] d;
        @(negedge ref_clk_i) nv = 1'b1;
        host.scan(1'b1, 8, 136'h01, d);
        wref(10);
        chk({io_en, pad_out, pad_oe, core_in}, {1'b1, core_out, core_oe, pad_in});
        host.scan(1'b0, 12, 136'hA5C, d);
        chk({d[9], d[6], d[3], d[0]}, pad_in);
        host.scan(1'b1, 8, 136'h00, d);
        wref(10);
        chk({pad_out, pad_oe}, 8'h29);
        host.scan(1'b1, 8, 136'h07, d);
        wref(10);
        chk(pad_oe, 4'h0);
        @(negedge ref_clk_i) nv = 1'b0;
        wref(10);
        host.scan(1'b1, 8, 136'h01, d);
        host.scan(1'b0, 12, 136'h0, d);
        chk({io_en, pad_oe, core_in, d[9], d[6], d[3], d[0]}, 13'h0);
        $display("t_pins done");
    endtask
    task automatic t_prog(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] tag);
        logic [127:0] pl;
        logic [135:0] d;
        int w0;
        pl = {tag, 120'h0123_4567_89AB_CDEF_FEDC_BA98_7654_32};
        w0 = n_wr;
        host.scan(1'b1, 8, 136'(op), d);
        host.scan(1'b0, 136, {adr, enc(pl)}, d);
        for (int k = 0; k < 20 && busy !== 1'b1; k++)
            @(negedge ref_clk_i);
        for (int k = 0; k < 80 && busy !== 1'b0; k++)
            @(negedge ref_clk_i);
        chk({busy, ok, err}, {1'b0, tag == 8'hA5, tag != 8'hA5});
        chk(n_wr - w0, op == 8'h10 && tag == 8'hA5);
        if (n_wr != w0)
            chk({wr_addr, fab_rdata}, {adr, pl});
        $display("t_prog done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial
    begin
        rst_i = 1'b1;
        nv = 1'b0;
        core_out = 4'hD;
        core_oe = 4'h6;
        pad_in = 4'h9;
        wref(6);
        rst_i = 1'b0;
        host.trst_pulse();
        t_reset();
        t_opcodes();
        t_pins();
        t_prog(8'h10, 8'h3C, 8'hA5);
        t_prog(8'h10, 8'h3C, 8'h5A);
        t_prog(8'h11, 8'h05, 8'hA5);
        finish_test();
    end
    // watchdog
    initial
    begin
        #500_000;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
